// ==== common/wckb_defines.vh ====
`ifndef WCKB_DEFINES_VH
`define WCKB_DEFINES_VH

// Wide key type codes
`define WCKB_TYPE_FULL_L2     2'h0
`define WCKB_TYPE_NORMAL      2'h1
`define WCKB_TYPE_FIVE_TUPLE  2'h2
`define WCKB_TYPE_CUSTOM      2'h3

// Port mask modes
`define WCKB_MASK_DEFAULT     2'h0
`define WCKB_MASK_LOOPBACK    2'h1
`define WCKB_MASK_MASQ        2'h2
`define WCKB_MASK_SPECIAL     2'h3

// Next index control codes
`define WCKB_NXT_NONE         2'h0
`define WCKB_NXT_VALUE        2'h1
`define WCKB_NXT_SERVICE      2'h2

// Default binding index select codes
`define WCKB_DEF_ZERO         2'h0
`define WCKB_DEF_LPORT        2'h1
`define WCKB_DEF_MASQ         2'h2

// Pipeline action code for masquerade injection
`define WCKB_ACT_INJ_MASQ     3'h3

// Special physical source ports
`define WCKB_PORT_CPU_PORT_ZERO        6'h35
`define WCKB_PORT_CPU_PORT_ONE        6'h36
`define WCKB_PORT_VD0         6'h37
`define WCKB_PORT_VD1         6'h38

// Mode 3 bitmap field positions
`define WCKB_M3_SRC_LSB       4
`define WCKB_M3_SRC_MSB       9
`define WCKB_M3_PT_LSB        44
`define WCKB_M3_PT_MSB        48
`define WCKB_M3_ACT_LSB       49
`define WCKB_M3_ACT_MSB       51

// Wide key field positions
`define WCKB_K_TYPE_LSB       0
`define WCKB_K_TYPE_MSB       1
`define WCKB_K_FIRST          2
`define WCKB_K_PORT_LSB       3
`define WCKB_K_PORT_MSB       8
`define WCKB_K_SVC            9
`define WCKB_K_GIDX_LSB       10
`define WCKB_K_GIDX_MSB       21
`define WCKB_K_MSEL_LSB       22
`define WCKB_K_MSEL_MSB       23
`define WCKB_K_MASK_LSB       24
`define WCKB_K_MASK_MSB       76
`define WCKB_K_MC             77
`define WCKB_K_BC             78
`define WCKB_KEY_W            79

`endif

// ==== rtl/wckb_key_builder.v ====
// Overview of operation
// - Every wide key carries a 2-bit type code: full, normal, five-tuple, custom.
// - Every wide key carries a first-lookup flag, set first, cleared second.
// - Full layer-2 key carries the 6-bit configured logical ingress port.
// - Service flag set when previous action chose service index as binding index.
// - 12-bit binding index built from previous next-index control and value.
// - Without previous action, binding index is zero, logical or masqueraded port.
// - Port-mask mode is 2 bits; 0 default, 1 for loopback-device frames.
// - Mode 2 for masqueraded frames when the masquerade mask enable is set.
// - Mode 3 for CPU, virtual device or loopback frames with their enables.
// - When several modes qualify, the highest qualifying mode wins.
// - 53-bit bitmap: physical, looped or masqueraded port bit per mode.
// - Mode 3 bitmap: source flags, source port, pipeline point and action.
// - Multicast flag is bit 40 of the destination MAC.
// - Broadcast flag set when destination MAC is all ones.
`timescale 1ns/100ps
`default_nettype none
`include "wckb_defines.vh"

module wckb_key_builder #(
  parameter MASK_W = 53
) (
  input  wire                 clk_in,
  input  wire                 rst_b_in,
  input  wire                 build_valid_in,
  input  wire [1:0]           key_type_in,
  input  wire                 first_lookup_in,
  input  wire [5:0]           logical_port_number_in,
  input  wire [5:0]           phys_src_port_in,
  input  wire [5:0]           ifh_src_port_in,
  input  wire                 inject_mode_in,
  input  wire                 cpu_injected_in,
  input  wire                 loopback_device_in,
  input  wire [5:0]           looped_port_in,
  input  wire [4:0]           pipeline_point_in,
  input  wire [2:0]           pipeline_action_in,
  input  wire                 prev_action_valid_in,
  input  wire [1:0]           next_index_control_in,
  input  wire [11:0]          next_index_value_in,
  input  wire [11:0]          service_index_in,
  input  wire [1:0]           default_binding_index_select_in,
  input  wire                 masquerade_mask_enable_in,
  input  wire                 cpu_inject_mask_enable_in,
  input  wire                 virtual_device_mask_enable_in,
  input  wire                 loopback_mode3_enable_in,
  input  wire [47:0]          dest_mac_in,
  output reg                  key_valid_out,
  output reg  [1:0]           wide_key_type_code_out,
  output reg                  first_lookup_out,
  output reg  [5:0]           ingress_logical_port_out,
  output reg                  binding_index_from_service_out,
  output reg  [11:0]          binding_index_out,
  output reg  [1:0]           port_mask_mode_out,
  output reg  [MASK_W-1:0]    ingress_port_bitmap_out,
  output reg                  dest_mac_multicast_flag_out,
  output reg                  dest_mac_broadcast_flag_out,
  output reg  [`WCKB_KEY_W-1:0] wide_key_out
);

  ////////////////////////////////////////////////////////////////////////
  // Frame classification

  wire masq_frame;
  wire vd_frame;
  wire masq_q_mode;
  wire special_mode;
  wire [5:0] masq_port;

  // Injected with a foreign source port, or masquerade injection action
  assign masq_frame = (inject_mode_in &&
                       (ifh_src_port_in != phys_src_port_in)) ||
                      (pipeline_action_in == `WCKB_ACT_INJ_MASQ);
  assign masq_port  = masq_frame ? ifh_src_port_in : phys_src_port_in;

  assign vd_frame = (phys_src_port_in == `WCKB_PORT_VD0) ||
                    (phys_src_port_in == `WCKB_PORT_VD1);

  assign masq_q_mode  = masq_frame && masquerade_mask_enable_in;
  assign special_mode =
    (cpu_injected_in && cpu_inject_mask_enable_in) ||
    (vd_frame && virtual_device_mask_enable_in) ||
    (loopback_device_in && loopback_mode3_enable_in);

  ////////////////////////////////////////////////////////////////////////
  // Port mask mode, highest qualifying value wins

  reg [1:0] mode_d;

  always @* begin
    if (special_mode) begin
      mode_d = `WCKB_MASK_SPECIAL;
    end else if (masq_q_mode) begin
      mode_d = `WCKB_MASK_MASQ;
    end else if (loopback_device_in) begin
      mode_d = `WCKB_MASK_LOOPBACK;
    end else begin
      mode_d = `WCKB_MASK_DEFAULT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ingress port bitmap

  reg  [5:0]        sel_port;
  wire [MASK_W-1:0] onehot;
  reg  [MASK_W-1:0] bitmap_d;

  always @* begin
    case (mode_d)
      `WCKB_MASK_LOOPBACK: begin
        sel_port = looped_port_in;
      end
      `WCKB_MASK_MASQ: begin
        sel_port = masq_port;
      end
      default: begin
        sel_port = phys_src_port_in;
      end
    endcase
  end

  // Port numbers beyond the mask width set no bit
  genvar gi;
  generate
    for (gi = 0; gi < MASK_W; gi = gi + 1) begin : g_onehot
      assign onehot[gi] = (sel_port == gi[5:0]);
    end
  endgenerate

  always @* begin
    bitmap_d = {MASK_W{1'b0}};
    if (mode_d == `WCKB_MASK_SPECIAL) begin
      bitmap_d[0] = (phys_src_port_in == `WCKB_PORT_CPU_PORT_ZERO);
      bitmap_d[1] = (phys_src_port_in == `WCKB_PORT_CPU_PORT_ONE);
      bitmap_d[2] = (phys_src_port_in == `WCKB_PORT_VD0);
      bitmap_d[3] = (phys_src_port_in == `WCKB_PORT_VD1);
      bitmap_d[`WCKB_M3_SRC_MSB:`WCKB_M3_SRC_LSB] = masq_port;
      bitmap_d[`WCKB_M3_PT_MSB:`WCKB_M3_PT_LSB] =
        pipeline_point_in;
      bitmap_d[`WCKB_M3_ACT_MSB:`WCKB_M3_ACT_LSB] =
        pipeline_action_in;
    end else begin
      bitmap_d = onehot;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Generic binding index

  reg [11:0] gidx_d;
  reg        svc_d;

  always @* begin
    svc_d = 1'b0;
    if (prev_action_valid_in &&
        next_index_control_in == `WCKB_NXT_VALUE) begin
      gidx_d = next_index_value_in;
    end else if (prev_action_valid_in &&
                 next_index_control_in == `WCKB_NXT_SERVICE) begin
      gidx_d = service_index_in;
      svc_d  = 1'b1;
    end else begin
      // No usable previous action: fall back to configured default
      case (default_binding_index_select_in)
        `WCKB_DEF_LPORT: begin
          gidx_d = {6'h00, logical_port_number_in};
        end
        `WCKB_DEF_MASQ: begin
          gidx_d = {6'h00, masq_port};
        end
        default: begin
          gidx_d = 12'h000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Destination MAC flags

  wire mc_d;
  wire bc_d;

  assign mc_d = dest_mac_in[40];
  assign bc_d = (dest_mac_in == 48'hFFFFFFFFFFFF);

  ////////////////////////////////////////////////////////////////////////
  // Key assembly at fixed positions

  reg  [`WCKB_KEY_W-1:0] key_d;
  wire                   is_full;
  wire                   has_mask;

  assign is_full  = (key_type_in == `WCKB_TYPE_FULL_L2);
  // Mask and MAC flags only exist in the two MAC-carrying key types
  assign has_mask = is_full || (key_type_in == `WCKB_TYPE_NORMAL);

  always @* begin
    key_d = {`WCKB_KEY_W{1'b0}};
    key_d[`WCKB_K_TYPE_MSB:`WCKB_K_TYPE_LSB] = key_type_in;
    key_d[`WCKB_K_FIRST] = first_lookup_in;
    if (is_full) begin
      key_d[`WCKB_K_PORT_MSB:`WCKB_K_PORT_LSB] =
        logical_port_number_in;
    end else begin
      key_d[`WCKB_K_SVC] = svc_d;
      key_d[`WCKB_K_GIDX_MSB:`WCKB_K_GIDX_LSB] = gidx_d;
    end
    if (has_mask) begin
      key_d[`WCKB_K_MSEL_MSB:`WCKB_K_MSEL_LSB] = mode_d;
      key_d[`WCKB_K_MASK_MSB:`WCKB_K_MASK_LSB] = bitmap_d[52:0];
      key_d[`WCKB_K_MC] = mc_d;
      key_d[`WCKB_K_BC] = bc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output registers, one cycle from request to key

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      key_valid_out                  <= 1'b0;
      wide_key_type_code_out         <= 2'h0;
      first_lookup_out               <= 1'b0;
      ingress_logical_port_out       <= 6'h00;
      binding_index_from_service_out <= 1'b0;
      binding_index_out              <= 12'h000;
      port_mask_mode_out             <= 2'h0;
      ingress_port_bitmap_out        <= {MASK_W{1'b0}};
      dest_mac_multicast_flag_out    <= 1'b0;
      dest_mac_broadcast_flag_out    <= 1'b0;
      wide_key_out                   <= {`WCKB_KEY_W{1'b0}};
    end else begin
      key_valid_out <= build_valid_in;
      // Fields load only with a request so the key holds between frames
      if (build_valid_in) begin
        wide_key_type_code_out         <= key_type_in;
        first_lookup_out               <= first_lookup_in;
        ingress_logical_port_out       <= logical_port_number_in;
        binding_index_from_service_out <= svc_d;
        binding_index_out              <= gidx_d;
        port_mask_mode_out             <= mode_d;
        ingress_port_bitmap_out        <= bitmap_d;
        dest_mac_multicast_flag_out    <= mc_d;
        dest_mac_broadcast_flag_out    <= bc_d;
        wide_key_out                   <= key_d;
      end
    end
  end

endmodule

`default_nettype wire

// ==== verification/wckb_key_builder_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module wckb_key_builder_chk #(
  parameter MASK_W = 53
) (
  input wire logic              clk_in,
  input wire logic              rst_b_in,
  input wire logic              build_valid_in,
  input wire logic [1:0]        key_type_in,
  input wire logic [5:0]        logical_port_number_in,
  input wire logic              cpu_injected_in,
  input wire logic              cpu_inject_mask_enable_in,
  input wire logic              prev_action_valid_in,
  input wire logic [1:0]        next_index_control_in,
  input wire logic [11:0]       service_index_in,
  input wire logic [47:0]       dest_mac_in,
  input wire logic              key_valid_out,
  input wire logic [1:0]        wide_key_type_code_out,
  input wire logic [5:0]        ingress_logical_port_out,
  input wire logic              binding_index_from_service_out,
  input wire logic [11:0]       binding_index_out,
  input wire logic [1:0]        port_mask_mode_out,
  input wire logic [MASK_W-1:0] ingress_port_bitmap_out,
  input wire logic              dest_mac_multicast_flag_out,
  input wire logic              dest_mac_broadcast_flag_out,
  input wire logic [78:0]       wide_key_out
);
  wire mc_bit = dest_mac_in[40];
  wire all_ones = &dest_mac_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  key_latency_a:
    assert property (build_valid_in |=> key_valid_out) else $error("late key");
  idle_hold_a:
    assert property (!build_valid_in |=> !key_valid_out &&
      $stable(wide_key_out)) else $error("key moved while idle");
  type_code_a:
    assert property (build_valid_in |=> wide_key_type_code_out ==
      $past(key_type_in)) else $error("bad type code");
  logical_port_a:
    assert property (build_valid_in |=> ingress_logical_port_out ==
      $past(logical_port_number_in)) else $error("bad logical port");
  multicast_bit_a:
    assert property (build_valid_in |=> dest_mac_multicast_flag_out ==
      $past(mc_bit)) else $error("bad multicast flag");
  broadcast_flag_a:
    assert property (build_valid_in |=> dest_mac_broadcast_flag_out ==
      $past(all_ones)) else $error("bad broadcast flag");
  service_index_a:
    assert property (build_valid_in && prev_action_valid_in &&
      next_index_control_in == 2'h2 |=> binding_index_from_service_out &&
      binding_index_out == $past(service_index_in)) else $error("bad index");
  cpu_mode_a:
    assert property (build_valid_in && cpu_injected_in &&
      cpu_inject_mask_enable_in |=> port_mask_mode_out == 2'h3)
      else $error("cpu frame not mode 3");
  reserved_bit_a:
    assert property (key_valid_out && port_mask_mode_out == 2'h3 |->
      !ingress_port_bitmap_out[MASK_W-1]) else $error("reserved bit set");
endmodule
bind wckb_key_builder wckb_key_builder_chk #(.MASK_W(MASK_W))
  u_wckb_key_builder_chk (.*);
`default_nettype wire

// ==== verification/wckb_tcam_sink.sv ====
`timescale 1ns/100ps
`default_nettype none
module wckb_tcam_sink (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        key_valid_in,
  input  wire logic [78:0] wide_key_in,
  output var  logic [15:0] key_count_out,
  output var  logic [78:0] last_key_out
);
  // Match stage takes every key with no back-pressure
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      key_count_out <= 16'h0000;
      last_key_out <= 79'h0;
    end else if (key_valid_in) begin
      key_count_out <= key_count_out + 16'h0001;
      last_key_out <= wide_key_in;
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "wckb_defines.vh"
module tb_top;
  reg          clk_in = 1'b0;
  reg          rst_b_in = 1'b0;
  reg          bv, fl, im, ci, lb, pav, me, ce, ve, le, pend;
  reg  [1:0]   kt, ctl, sel;
  reg  [5:0]   lpn, phys, ifh, lp;
  reg  [4:0]   pt;
  reg  [2:0]   act;
  reg  [11:0]  nv, si;
  reg  [47:0]  dmac;
  reg  [79:0]  ev;
  reg  [78:0]  ek;
  reg  [63:0]  r;
  wire         kv, fo, so, mc, bc;
  wire [1:0]   to, mo;
  wire [5:0]   po;
  wire [11:0]  go;
  wire [52:0]  bo;
  wire [78:0]  ko, lk;
  wire [15:0]  cnt;
  integer      seed = 48, fails = 0, samples_checked = 0, cyc = 0, n = 0, i;
  always #5 clk_in = ~clk_in;
  wckb_key_builder u_wckb_key_builder (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .build_valid_in(bv),
    .key_type_in(kt), .first_lookup_in(fl), .logical_port_number_in(lpn),
    .phys_src_port_in(phys), .ifh_src_port_in(ifh), .inject_mode_in(im),
    .cpu_injected_in(ci), .loopback_device_in(lb), .looped_port_in(lp),
    .pipeline_point_in(pt), .pipeline_action_in(act),
    .prev_action_valid_in(pav), .next_index_control_in(ctl),
    .next_index_value_in(nv), .service_index_in(si),
    .default_binding_index_select_in(sel), .masquerade_mask_enable_in(me),
    .cpu_inject_mask_enable_in(ce), .virtual_device_mask_enable_in(ve),
    .loopback_mode3_enable_in(le), .dest_mac_in(dmac), .key_valid_out(kv),
    .wide_key_type_code_out(to), .first_lookup_out(fo),
    .ingress_logical_port_out(po), .binding_index_from_service_out(so),
    .binding_index_out(go), .port_mask_mode_out(mo),
    .ingress_port_bitmap_out(bo), .dest_mac_multicast_flag_out(mc),
    .dest_mac_broadcast_flag_out(bc), .wide_key_out(ko));
  wckb_tcam_sink u_wckb_tcam_sink (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .key_valid_in(kv), .wide_key_in(ko), .key_count_out(cnt),
    .last_key_out(lk));
  ////////////////////////////////////////////////////////////////////////////
  function [79:0] calc();
    reg masq; reg [5:0] mp, p; reg [1:0] m; reg [52:0] b; reg [11:0] g;
    begin
      masq = (im && ifh != phys) || act == `WCKB_ACT_INJ_MASQ;
      mp = masq ? ifh : phys;
      m = lb ? 2'h1 : 2'h0;
      if (masq && me) m = 2'h2;
      if ((ci && ce) || (lb && le) || (ve && (phys == `WCKB_PORT_VD0 ||
          phys == `WCKB_PORT_VD1))) m = 2'h3;
      p = (m == 2'h0) ? phys : (m == 2'h1) ? lp : mp;
      b = (p < 6'h35) ? (53'h1 << p) : 53'h0;
      if (m == 2'h3) b = {1'b0, act, pt, 34'h0, mp, phys == `WCKB_PORT_VD1,
        phys == `WCKB_PORT_VD0, phys == `WCKB_PORT_CPU_PORT_ONE,
        phys == `WCKB_PORT_CPU_PORT_ZERO};
      g = (sel == 2'h1) ? {6'h00, lpn} : (sel == 2'h2) ? {6'h00, mp} : 12'h0;
      if (pav && ctl == 2'h1) g = nv;
      if (pav && ctl == 2'h2) g = si;
      calc = {1'b1, kt, fl, lpn, pav && ctl == 2'h2, g, m, b, dmac[40], &dmac};
    end
  endfunction
  function [78:0] keyof(input [79:0] e);
    begin
      keyof = {e[0], e[1], e[54:2], e[56:55], e[68:57], e[69], e[75:70],
        e[76], e[78:77]};
      if (e[78:77] == 2'h0) keyof[21:9] = 13'h0; else keyof[8:3] = 6'h00;
      if (e[78]) keyof[78:22] = 57'h0;
    end
  endfunction
  task cmp(input [79:0] g, input [79:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // Inputs keep changing on idle cycles to show the key only moves on requests
  task req(input v);
    begin
      cmp({kv, ko}, {pend, ek});
      if (pend)
        cmp({kv, to, fo, po, so, go, mo, bo, mc, bc}, ev);
      r = {$random(seed), $random(seed)};
      {kt, fl, lpn, lp, im, ci, lb, pav, ctl, sel, me, ce, ve, le, pt, act,
        nv, si} = r[58:0];
      r = {$random(seed), $random(seed)};
      phys = r[63] ? 6'h35 + {4'h0, r[62:61]} : r[5:0];
      ifh = r[60] ? phys : r[11:6];
      dmac = (r[59:58] == 2'h0) ? 48'hFFFFFFFFFFFF : r[47:0];
      if (v) ev = calc();
      if (v) ek = keyof(ev);
      if (v) n = n + 1;
      pend = v;
      bv = v;
      @(posedge clk_in);
      #1;
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      fails = fails + 1;
      results;
    end
  end
  initial begin
    {bv, fl, im, ci, lb, pav, me, ce, ve, le, pend} = 11'h000;
    {kt, ctl, sel, lpn, phys, ifh, lp, pt, act, nv, si} = 62'h0;
    {dmac, ev, ek} = 207'h0;
    repeat (20) @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    for (i = 0; i < 600; i = i + 1)
      req(i < 40 || ($random(seed) & 3) != 0);
    req(1'b0);
    cmp({64'h0, cnt}, {48'h0, n});
    cmp({1'b0, lk}, {1'b0, ek});
    $display("random burst test done");
    rst_b_in = 1'b0;
    #1;
    cmp({kv, ko}, 80'h0);
    pend = 1'b0;
    ek = 79'h0;
    @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    for (i = 0; i < 100; i = i + 1)
      req(($random(seed) & 1) != 0);
    req(1'b0);
    $display("reset recovery test done");
    results;
  end
endmodule
`default_nettype wire
